// ==== src/wwc_pkg.sv ====
// Shared constants, types and the register map of the cellular module control block.
// Assumes one 125 MHz clock and an APB master with 32-bit data.
package wwc_pkg;

    // Clock rate in MHz, used to turn milliseconds into cycles.
    localparam int CLK_MHZ      = 125;
    // Least time the power control pin must stay low before the module is off.
    localparam int OFF_HOLD_MS  = 500;
    localparam int OFF_HOLD_CYC = OFF_HOLD_MS * CLK_MHZ * 1000;

    // APB address width and register byte offsets.
    localparam int         ADDR_W   = 12;
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] EVT_OFF  = 12'h008;

    // Synchronised control pins, most significant first.
    typedef struct packed {
        logic pwr_on;       // Power control, high means on.
        logic radio_off_n;  // Low forces the radio off.
        logic pos_off_n;    // Low forces positioning off.
        logic prox_n;       // Low requests transmit power backoff.
        logic card;         // High means a card is present.
    } wwc_pins_s;

    // Idle pin levels: power pulled down, the rest pulled up.
    localparam logic [4:0] PINS_RST = 5'h0F;

    // Control register: software enables and the wake request.
    typedef struct packed {
        logic [28:0] rsvd;
        logic        wake;
        logic        pos_en;
        logic        radio_en;
    } wwc_ctrl_s;
    localparam logic [31:0] CTRL_RST = 32'h0000_0003;

    // Status register: live state of the block.
    typedef struct packed {
        logic [26:0] rsvd;
        logic        card;
        logic        backoff;
        logic        pos_on;
        logic        radio_on;
        logic        module_on;
    } wwc_stat_s;

    // Sticky card events, cleared by writing one.
    typedef struct packed {
        logic removed;
        logic inserted;
    } wwc_evt_s;
    localparam logic [1:0] EVT_RST = 2'h0;

    // Power state, Gray coded along off, on, draining.
    typedef enum logic [1:0] {
        PWR_OFF   = 2'b00,
        PWR_ON    = 2'b01,
        PWR_DRAIN = 2'b11
    } wwc_pwr_e;

endpackage

// ==== src/wwc_sync.sv ====
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk; the reset value sets each idle level.
`timescale 1ns/1ps
module wwc_sync #(
    parameter int         W       = 5,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Raw and synchronised levels.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // First stage; only the second stage reads it.
    logic [W-1:0] meta_q;

    // Both stages reset to the pull levels so a floating pin reads idle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ==== src/wwc_ctrl.sv ====
// Pin control and status logic of a cellular module, seen from inside the module.
// Assumes host-driven level pins, an APB master on CLK and open-drain pads outside.
`timescale 1ns/1ps
// What this block does
// R1: Power on while power pin high.
// R2: Undriven power pin reads low.
// R3: Status lamp is open-drain, active low.
// R4: Radio-off low kills radio, else software.
// R5: Positioning-off low kills positioning, else software.
// R6: Wake host by pulling wake low.
// R7: Proximity low applies transmit power backoff.
// R8: Card edges mean insertion and removal.
// R9: Host holds supply low 100 ms; this block has no supply input and does nothing for it.
// R10: Restart low resets module asynchronously.
// R11: Power off after 500 ms low.
// R12: Lamp low while radio on.
// R13: Synchronise every asynchronous control input.
module wwc_ctrl
    import wwc_pkg::*;
#(
    parameter int OFF_CYCLES = OFF_HOLD_CYC
) (
    // Clock and reset.
    input  wire logic              CLK,
    input  wire logic              NRST,
    // Host control pins.
    input  wire logic              POWER_CTRL,
    input  wire logic              RESTART_N,
    input  wire logic              RADIO_OFF_N,
    input  wire logic              POSITIONING_OFF_N,
    input  wire logic              PROXIMITY_BACKOFF_N,
    input  wire logic              CARD_PRESENCE,
    // Open-drain outputs to the host.
    output logic                   STATUS_LAMP_N_O,
    output logic                   STATUS_LAMP_N_OE,
    output logic                   HOST_WAKEUP_N_O,
    output logic                   HOST_WAKEUP_N_OE,
    // Controls to the module internals.
    output logic                   MODULE_ON,
    output logic                   RADIO_EN,
    output logic                   POSITIONING_EN,
    output logic                   TX_BACKOFF,
    output logic                   CARD_PRESENT,
    // APB slave.
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR
);

    // Internal reset: either reset input asserts at once, release is synchronised.
    logic       rst_req_n;     // Combined asynchronous reset request.
    logic [1:0] rst_sync_q;    // Release synchroniser.
    logic       rst_n;         // Reset used by every flop below except the release synchroniser.

    assign rst_req_n = NRST & RESTART_N; // R10

    // The restart pin acts without the clock, so a stopped clock cannot mask it.
    always_ff @(posedge CLK or negedge rst_req_n) begin
        if (!rst_req_n) begin
            rst_sync_q <= 2'b00; // R10
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pin synchronisers; idle levels follow the pad pulls.
    logic [4:0] pins_raw;      // Raw pin levels.
    logic [4:0] pins_vec;      // Synchronised levels.
    wwc_pins_s  pin_s;         // Synchronised levels by name.

    assign pins_raw = {POWER_CTRL, RADIO_OFF_N, POSITIONING_OFF_N,
                       PROXIMITY_BACKOFF_N, CARD_PRESENCE};

    // Power resets low and the others high, so an undriven pin reads its pull.
    wwc_sync #(
        .W       (5),
        .RST_VAL (PINS_RST) // R2
    ) u_sync (
        .clk   (CLK),
        .rst_n (rst_n),
        .d     (pins_raw), // R13
        .q     (pins_vec)
    );
    assign pin_s = wwc_pins_s'(pins_vec);

    // Power state machine and the low-time counter.
    wwc_pwr_e    state_q;      // Present power state.
    wwc_pwr_e    state_d;      // Next power state.
    logic [31:0] off_cnt_q;    // Cycles spent low while draining.
    logic [31:0] off_cnt_d;    // Next count.

    // A short low glitch must not drop power, so the pin is timed before shutting down.
    always_comb begin
        state_d = state_q;
        case (state_q)
            PWR_OFF: begin
                // Power follows a high pin at once.
                if (pin_s.pwr_on) state_d = PWR_ON; // R1
            end
            PWR_ON: begin
                if (!pin_s.pwr_on) state_d = PWR_DRAIN;
            end
            PWR_DRAIN: begin
                // Off only once the pin has stayed low past the hold time.
                if (pin_s.pwr_on) begin
                    state_d = PWR_ON;
                end else if (off_cnt_q == 32'(OFF_CYCLES)) begin
                    state_d = PWR_OFF; // R11
                end
            end
            default: begin
                state_d = PWR_OFF;
            end
        endcase
    end

    assign off_cnt_d = (state_q == PWR_DRAIN && !pin_s.pwr_on) ? off_cnt_q + 32'h0000_0001
                                                               : 32'h0000_0000;

    // State and counter flops.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= PWR_OFF;
            off_cnt_q <= 32'h0000_0000;
        end else begin
            state_q   <= state_d;
            off_cnt_q <= off_cnt_d;
        end
    end

    // The on and draining codes share bit 0, so it is the powered flag.
    assign MODULE_ON = state_q[0]; // R1

    // Software registers.
    wwc_ctrl_s ctrl_q;         // Control register.
    wwc_ctrl_s ctrl_d;
    wwc_evt_s  evt_q;          // Sticky card events.
    wwc_evt_s  evt_d;

    // Function enables, registered so the pins see clean levels.
    logic radio_on_q;
    logic radio_on_d;
    logic pos_on_q;
    logic pos_on_d;
    logic backoff_q;
    logic backoff_d;
    logic wake_q;
    logic wake_d;
    logic card_q;              // Previous card level, for edges.

    // For radio and positioning a low pin always wins; a high pin leaves the software setting in charge.
    assign radio_on_d = MODULE_ON & pin_s.radio_off_n & ctrl_q.radio_en; // R4
    assign pos_on_d   = MODULE_ON & pin_s.pos_off_n & ctrl_q.pos_en; // R5
    assign backoff_d  = MODULE_ON & ~pin_s.prox_n; // R7
    assign wake_d     = MODULE_ON & ctrl_q.wake; // R6

    // Card edges, taken only from the synchronised level.
    logic card_ins;
    logic card_rem;
    assign card_ins = pin_s.card & ~card_q; // R8
    assign card_rem = ~pin_s.card & card_q; // R8

    // APB decode; the slave never waits.
    logic        apb_setup;
    logic        apb_wr;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_evt;
    logic        hit_any;
    wwc_stat_s   stat_w;
    logic [31:0] rd_mux;
    logic [31:0] prdata_q;

    assign apb_setup = PSEL & ~PENABLE;
    assign apb_wr    = PSEL & PENABLE & PWRITE;
    assign hit_ctrl  = (PADDR == CTRL_OFF);
    assign hit_stat  = (PADDR == STAT_OFF);
    assign hit_evt   = (PADDR == EVT_OFF);
    assign hit_any   = hit_ctrl | hit_stat | hit_evt;

    assign stat_w = '{rsvd: 27'h000_0000, card: card_q, backoff: backoff_q,
                      pos_on: pos_on_q, radio_on: radio_on_q, module_on: MODULE_ON};

    assign rd_mux = hit_ctrl ? 32'(ctrl_q) :
                    hit_stat ? 32'(stat_w) :
                    hit_evt  ? {30'h0000_0000, evt_q} : 32'h0000_0000;

    // Reserved control bits are not stored so they always read zero.
    assign ctrl_d = (apb_wr && hit_ctrl) ? wwc_ctrl_s'({29'h0000_0000, PWDATA[2:0]}) : ctrl_q;

    // A new edge beats a clear in the same cycle.
    assign evt_d = (evt_q & ~((apb_wr && hit_evt) ? PWDATA[1:0] : 2'b00))
                 | {card_rem, card_ins}; // R8

    // Register and output flops.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= wwc_ctrl_s'(CTRL_RST);
            evt_q      <= wwc_evt_s'(EVT_RST);
            radio_on_q <= 1'b0;
            pos_on_q   <= 1'b0;
            backoff_q  <= 1'b0;
            wake_q     <= 1'b0;
            card_q     <= PINS_RST[0];
            prdata_q   <= 32'h0000_0000;
        end else begin
            ctrl_q     <= ctrl_d;
            evt_q      <= evt_d;
            radio_on_q <= radio_on_d;
            pos_on_q   <= pos_on_d;
            backoff_q  <= backoff_d;
            wake_q     <= wake_d;
            card_q     <= pin_s.card;
            // Read data is captured in the setup cycle and held through the access.
            prdata_q   <= (apb_setup && !PWRITE) ? rd_mux : prdata_q;
        end
    end

    // Open-drain pads: data is always low, the enable pulls the line.
    assign STATUS_LAMP_N_O  = 1'b0; // R3
    assign STATUS_LAMP_N_OE = radio_on_q; // R12
    assign HOST_WAKEUP_N_O  = 1'b0;
    assign HOST_WAKEUP_N_OE = wake_q; // R6

    assign RADIO_EN       = radio_on_q;
    assign POSITIONING_EN = pos_on_q;
    assign TX_BACKOFF     = backoff_q;
    assign CARD_PRESENT   = card_q;

    assign PRDATA  = prdata_q;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit_any;

    // Checks on the pin behaviour.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    sequence card_rise_s;
        !pin_s.card ##1 pin_s.card;
    endsequence

    sequence card_fall_s;
        pin_s.card ##1 !pin_s.card;
    endsequence

    power_up_a: assert property ((state_q == PWR_OFF && pin_s.pwr_on) |=> MODULE_ON) // R1
        else $error("Module did not power on after the power pin rose.");
    power_hold_a: assert property ($fell(MODULE_ON) |-> $past(off_cnt_q) == 32'(OFF_CYCLES)) // R11
        else $error("Module powered off before the low hold time.");
    lamp_drain_a: assert property (!STATUS_LAMP_N_O) // R3
        else $error("Status lamp pad drives high.");
    lamp_follow_a: assert property ($fell(pin_s.radio_off_n) |=> !STATUS_LAMP_N_OE) // R12
        else $error("Status lamp stays lit after the radio was forced off.");
    radio_off_a: assert property ((!pin_s.radio_off_n) |=> !RADIO_EN ##1 !RADIO_EN || pin_s.radio_off_n) // R4
        else $error("Radio stayed on with the radio-off pin low.");
    pos_sw_a: assert property ((MODULE_ON && pin_s.pos_off_n && ctrl_q.pos_en
                               && state_d != PWR_OFF) |=> POSITIONING_EN) // R5
        else $error("Positioning not on although pin and software allow it.");
    backoff_a: assert property ((MODULE_ON && state_d != PWR_OFF) |-> ##1 (TX_BACKOFF == !$past(pin_s.prox_n))) // R7
        else $error("Transmit backoff does not follow the proximity pin.");
    wake_a: assert property ((!ctrl_q.wake) |=> !HOST_WAKEUP_N_OE) // R6
        else $error("Host wake pulled without a request.");
    insert_a: assert property (card_rise_s |=> evt_q.inserted) // R8
        else $error("Card insertion edge not recorded.");
    remove_a: assert property (card_fall_s |=> evt_q.removed) // R8
        else $error("Card removal edge not recorded.");

endmodule

// ==== tb/wwc_host.sv ====
// Host platform model: drives the module control pins, resolves the open-drain lines.
// Assumes both open-drain lines have a pull-up on the host board.
`timescale 1ns/1ps
module wwc_host
    import wwc_pkg::*;
(
    // Clock.
    input  wire logic clk,
    // Open-drain pull enables from the module.
    input  wire logic lamp_oe,
    input  wire logic wake_oe,
    // Pins driven by the host.
    output wwc_pins_s pins,
    output logic      restart_n,
    // Resolved line levels.
    output logic      lamp_n,
    output logic      wake_n
);
    // Released lines float up to the pull-up level, never the last driven value.
    // An open-drain pad can only pull low; the bench checks the data side itself.
    assign lamp_n = lamp_oe ? 1'b0 : 1'b1;
    assign wake_n = wake_oe ? 1'b0 : 1'b1;

    // Idle levels match the pad pulls until the host drives anything.
    initial begin
        pins      = PINS_RST;
        restart_n = 1'b1;
    end

    // Pin changes land just after a clock edge.
    task automatic set_pins(input wwc_pins_s p);
        @(posedge clk);
        pins <= p;
    endtask

    // Restart pulse; the host keeps it low well past the module minimum.
    task automatic pulse_restart(input int cyc);
        @(posedge clk);
        restart_n <= 1'b0;
        repeat (cyc) @(posedge clk);
        restart_n <= 1'b1;
    endtask

    // Power drop; the caller chooses a span below or above the off hold.
    task automatic drop_power(input int cyc);
        wwc_pins_s p;
        p        = pins;
        p.pwr_on = 1'b0;
        set_pins(p);
        repeat (cyc) @(posedge clk);
        p.pwr_on = 1'b1;
        set_pins(p);
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench of the control pin block with a host model and an APB master.
// Assumes an APB slave on the bench clock and a shortened power-off hold of 20 cycles.
`timescale 1ns/1ps
module tb_top
    import wwc_pkg::*;
;
    logic              clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              lamp_o, lamp_oe, wake_o, wake_oe, lamp_n, wake_n, restart_n;
    logic              mod_on, radio_en, pos_en, txb, card;
    wwc_pins_s         pins;
    int                num_errors = 0;
    int                cmp_count  = 0;
    // Rows: ctrl pos,radio; pins radio,pos,prox -> radio,pos,backoff,lamp line.
    logic [8:0]        rows [7] = '{9'h1FC, 9'h1B5, 9'h1D8, 9'h1EE,
                                    9'h0F8, 9'h175, 9'h003};

    wwc_host host (.clk(clk), .lamp_oe(lamp_oe), .wake_oe(wake_oe), .pins(pins),
        .restart_n(restart_n), .lamp_n(lamp_n), .wake_n(wake_n));

    wwc_ctrl #(.OFF_CYCLES(20)) dut (.CLK(clk), .NRST(nrst), .POWER_CTRL(pins.pwr_on),
        .RESTART_N(restart_n), .RADIO_OFF_N(pins.radio_off_n),
        .POSITIONING_OFF_N(pins.pos_off_n), .PROXIMITY_BACKOFF_N(pins.prox_n),
        .CARD_PRESENCE(pins.card), .STATUS_LAMP_N_O(lamp_o), .STATUS_LAMP_N_OE(lamp_oe),
        .HOST_WAKEUP_N_O(wake_o), .HOST_WAKEUP_N_OE(wake_oe), .MODULE_ON(mod_on),
        .RADIO_EN(radio_en), .POSITIONING_EN(pos_en), .TX_BACKOFF(txb),
        .CARD_PRESENT(card), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));

    // Free-running 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Counts every comparison and reports each mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the leading edge keeps back-to-back calls from clashing.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for a slave that never answers.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin levels need two sync edges and one output edge; eight leaves margin.
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    // Final verdict, shared by the main sequence and the watchdog.
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Cuts a hang short; the tests need a few hundred cycles at most.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("Watchdog expired");
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        settle();
        // Reset state with the power pin still low.
        chk(mod_on, 1'b0);
        chk(lamp_oe, 1'b0);
        apb(1'b0, CTRL_OFF, '0);
        chk(rd, CTRL_RST);
        chk(err, 1'b0);
        host.set_pins(5'h1F);
        settle();
        chk(mod_on, 1'b1);
        $display("Test reset and power-on done");
        // Table of pin and software combinations.
        foreach (rows[i]) begin
            apb(1'b1, CTRL_OFF, {30'h0, rows[i][8:7]});
            host.set_pins({1'b1, rows[i][6:4], 1'b1});
            settle();
            chk({radio_en, pos_en, txb, lamp_n}, rows[i][3:0]);
            chk(lamp_o, 1'b0);
            apb(1'b0, STAT_OFF, '0);
            chk(rd[3:0], {rows[i][1], rows[i][2], rows[i][3], 1'b1});
        end
        $display("Test pin table done");
        // Wake request pulls the host line low, release lets it float up.
        apb(1'b1, CTRL_OFF, 32'h0000_0007);
        settle();
        chk({wake_n, wake_o}, 2'b00);
        apb(1'b1, CTRL_OFF, CTRL_RST);
        settle();
        chk({wake_n, wake_oe}, 2'b10);
        $display("Test wake done");
        // Card removal then insertion, with write-one-to-clear in between.
        host.set_pins(5'h1E);
        settle();
        apb(1'b0, EVT_OFF, '0);
        chk(rd, 32'h0000_0002);
        chk(card, 1'b0);
        apb(1'b0, STAT_OFF, '0);
        chk(rd[4:0], 5'h07);
        apb(1'b1, EVT_OFF, 32'h0000_0002);
        host.set_pins(5'h1F);
        settle();
        apb(1'b0, EVT_OFF, '0);
        chk(rd, 32'h0000_0001);
        $display("Test card done");
        // Unmapped address: error, zero data, no side effect.
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b0, 12'h00C, '0);
        chk(rd, 32'h0000_0000);
        chk(err, 1'b1);
        apb(1'b0, CTRL_OFF, '0);
        chk(rd, CTRL_RST);
        $display("Test unmapped done");
        // The longest dip that must be ignored: power may not blink at any edge.
        fork
            host.drop_power(20);
            repeat (26) begin
                @(posedge clk);
                chk(mod_on, 1'b1);
            end
        join
        settle();
        chk(mod_on, 1'b1);
        host.drop_power(40);
        chk({mod_on, radio_en, lamp_n}, 3'b001);
        settle();
        chk(mod_on, 1'b1);
        $display("Test power-off hold done");
        // Restart takes effect without waiting for a clock edge.
        // Lamp and wake are both pulled first, so the restart has something to clear.
        apb(1'b1, CTRL_OFF, 32'h0000_0005);
        settle();
        chk({mod_on, lamp_oe, wake_oe}, 3'b111);
        fork
            host.pulse_restart(6);
            begin
                @(negedge restart_n);
                #1;
                chk({mod_on, lamp_oe, wake_oe}, 3'b000);
            end
        join
        settle();
        apb(1'b0, CTRL_OFF, '0);
        chk(rd, CTRL_RST);
        $display("Test restart done");
        tally_and_finish();
    end
endmodule
